// ===== proc_status_params.svh
// Constants for the processor status register slice.
// Assumes inclusion by the package only.
`ifndef PROC_STATUS_PARAMS_SVH
`define PROC_STATUS_PARAMS_SVH

// ==========================================================
// Register offsets
`define OFS_SECURITY      8'h05
`define OFS_OSC_CTRL      8'h06
`define OFS_OSC_COUNT0    8'h07
`define OFS_OSC_COUNT1    8'h08
`define OFS_OSC_COUNT2    8'h09
`define OFS_OSC_COUNT3    8'h0A
`define OFS_MEM_SIZE      8'h0C
`define OFS_SAVED_STATUS  8'h10
`define OFS_SAVED_PC      8'h11
`define OFS_SAVED_SP      8'h12
`define OFS_THREAD_SEL    8'h13
`define OFS_REG_SEL       8'h14

// ==========================================================
// Security word fields
`define SEC_WRITE_LOCK    31
`define SEC_GDBG_BLOCK    14
`define SEC_LOCK_ALL      12
`define SEC_SECTOR_HI     11
`define SEC_SECTOR_LO     8
`define SEC_REDUNDANCY    7
`define SEC_BOOT_OTP      5
`define SEC_CFG_SCAN      4
`define SEC_SCAN_DEBUG    0
`define SEC_IMPL_MASK     32'h8000_5FB1
`define SEC_RESET         32'h0000_0000

// ==========================================================
// Oscillator control fields
`define OSC_CORE_RUN      1
`define OSC_PERIPH_RUN    0
`define OSC_CTRL_MASK     32'h0000_0003
`define OSC_CTRL_RESET    32'h0000_0000

// ==========================================================
// Debug capture and memory size fields
`define SSR_IMPL_MASK     32'h0000_07DF
`define SSR_SW_MASK       32'h0000_06DF
`define SSR_ISSUE_MODE    8
`define THREAD_SEL_MASK   32'h0000_00FF
`define REG_SEL_MASK      32'h0000_001F
`define MEM_SIZE_MASK     32'hFFFF_FFFC
`define MEM_SIZE_BYTES    32'h0004_0000

`endif

// ===== proc_status_pkg.sv
// Types shared by the processor status register slice.
// Assumes the params header sits in the same folder.
package proc_status_pkg;
  `include "proc_status_params.svh"

  typedef logic [31:0] word_t;
  typedef logic [15:0] osc_count_t;
  typedef logic [7:0]  ps_addr_t;

  typedef enum {
    REG_NONE,
    REG_SECURITY,
    REG_OSC_CTRL,
    REG_OSC_COUNT,
    REG_MEM_SIZE,
    REG_SAVED_STATUS,
    REG_SAVED_PC,
    REG_SAVED_SP,
    REG_THREAD_SEL,
    REG_REG_SEL
  } reg_id_t;
endpackage

// ===== proc_status_regs.sv
// Processor status register slice: security word, oscillator
// counters, memory size and debug capture registers.
// Assumes status set/get strobes and debug inputs synchronous to clock.
`timescale 1ns/1ns
`default_nettype none

module proc_status_regs
  import proc_status_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        clockEnable,
  input  wire logic        psWrite,
  input  wire logic        psRead,
  input  wire logic [7:0]  psAddr,
  input  wire logic [31:0] psWrData,
  output var  logic [31:0] psRdData,
  output var  logic        psRdValid,
  output var  logic        psWrRefused,
  input  wire logic        otpSecLoad,
  input  wire logic [31:0] otpSecWord,
  input  wire logic        debugMode,
  input  wire logic        dbgEntry,
  input  wire logic [31:0] threadStatusWord,
  input  wire logic [31:0] savedPcWord,
  input  wire logic [31:0] savedSpWord,
  input  wire logic [3:0]  oscTap,
  output var  logic        coreOscRun,
  output var  logic        periphOscRun,
  output var  logic        writeLockSelf,
  output var  logic        globalDebugBlock,
  output var  logic        otpLockAll,
  output var  logic [3:0]  otpLockPerSector,
  output var  logic        otpRedundancyOn,
  output var  logic        bootFromOtpOverride,
  output var  logic        scanConfigBlock,
  output var  logic        scanDebugPortBlock,
  output var  logic [7:0]  targetThreadNumber,
  output var  logic [4:0]  debugRegisterSelect
);

  // ==========================================================
  // Reset release
  logic rstMeta_b;
  logic rstSync_b;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta_b <= 1'b0;
      rstSync_b <= 1'b0;
    end
    else
    begin
      rstMeta_b <= 1'b1;
      rstSync_b <= rstMeta_b;
    end
  end

  // ==========================================================
  // Address decode
  function automatic reg_id_t decodeAddr(input ps_addr_t a);
    reg_id_t r;
    r = REG_NONE;
    if (a == `OFS_SECURITY)
      r = REG_SECURITY;
    else if (a == `OFS_OSC_CTRL)
      r = REG_OSC_CTRL;
    else if (a >= `OFS_OSC_COUNT0 && a <= `OFS_OSC_COUNT3)
      r = REG_OSC_COUNT;
    else if (a == `OFS_MEM_SIZE)
      r = REG_MEM_SIZE;
    else if (a == `OFS_SAVED_STATUS)
      r = REG_SAVED_STATUS;
    else if (a == `OFS_SAVED_PC)
      r = REG_SAVED_PC;
    else if (a == `OFS_SAVED_SP)
      r = REG_SAVED_SP;
    else if (a == `OFS_THREAD_SEL)
      r = REG_THREAD_SEL;
    else if (a == `OFS_REG_SEL)
      r = REG_REG_SEL;
    return r;
  endfunction

  reg_id_t accessId;
  wire     debugAllowed;
  wire     wrSecurity;
  wire     wrOscCtrl;
  wire     wrDebug;
  wire     wrRefused;
  wire     captureEn;

  assign accessId     = decodeAddr(psAddr);
  assign debugAllowed = debugMode && !globalDebugBlock;
  assign wrSecurity   = psWrite && accessId == REG_SECURITY && !writeLockSelf;
  assign wrOscCtrl    = psWrite && accessId == REG_OSC_CTRL;
  assign wrDebug      = psWrite && debugAllowed;
  assign captureEn    = dbgEntry && !globalDebugBlock;
  assign wrRefused    = psWrite && ((accessId == REG_SECURITY && writeLockSelf)
                        || (!debugAllowed && (accessId == REG_SAVED_STATUS
                        || accessId == REG_SAVED_PC || accessId == REG_SAVED_SP
                        || accessId == REG_THREAD_SEL || accessId == REG_REG_SEL)));

  // ==========================================================
  // Security word
  word_t securityReg;
  word_t securityNext;

  assign securityNext = otpSecLoad ? (otpSecWord & `SEC_IMPL_MASK)
                        : wrSecurity ? (psWrData & `SEC_IMPL_MASK)
                        : securityReg;

  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
      securityReg <= `SEC_RESET;
    else if (clockEnable)
      securityReg <= securityNext;
  end

  assign writeLockSelf       = securityReg[`SEC_WRITE_LOCK];
  assign globalDebugBlock    = securityReg[`SEC_GDBG_BLOCK];
  assign otpLockAll          = securityReg[`SEC_LOCK_ALL];
  assign otpLockPerSector    = securityReg[`SEC_SECTOR_HI:`SEC_SECTOR_LO];
  assign otpRedundancyOn     = securityReg[`SEC_REDUNDANCY];
  assign bootFromOtpOverride = securityReg[`SEC_BOOT_OTP];
  assign scanConfigBlock     = securityReg[`SEC_CFG_SCAN];
  assign scanDebugPortBlock  = securityReg[`SEC_SCAN_DEBUG];

  // ==========================================================
  // Oscillator control
  word_t oscCtrlReg;
  word_t oscCtrlNext;

  assign oscCtrlNext = wrOscCtrl ? (psWrData & `OSC_CTRL_MASK) : oscCtrlReg;

  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
      oscCtrlReg <= `OSC_CTRL_RESET;
    else if (clockEnable)
      oscCtrlReg <= oscCtrlNext;
  end

  assign coreOscRun   = oscCtrlReg[`OSC_CORE_RUN];
  assign periphOscRun = oscCtrlReg[`OSC_PERIPH_RUN];

  // ==========================================================
  // Oscillator counters, no reset
  osc_count_t oscCount [4] = '{default: 16'h0000};
  logic [3:0] tapMeta;
  logic [3:0] tapSync;
  logic [3:0] tapPrev;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gOsc
      always_ff @(posedge clock)
      begin
        if (clockEnable)
        begin
          tapMeta[g] <= oscTap[g];
          tapSync[g] <= tapMeta[g];
          tapPrev[g] <= tapSync[g];
          if (tapSync[g] && !tapPrev[g])
            oscCount[g] <= oscCount[g] + 16'h0001;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Debug capture registers
  word_t savedStatusReg;
  word_t savedStatusNext;
  word_t savedPcReg;
  word_t savedPcNext;
  word_t savedSpReg;
  word_t savedSpNext;
  word_t threadSelReg;
  word_t threadSelNext;
  word_t regSelReg;
  word_t regSelNext;
  wire   wrStatus;

  assign wrStatus = wrDebug && accessId == REG_SAVED_STATUS;

  assign savedStatusNext = captureEn ? (threadStatusWord & `SSR_IMPL_MASK)
                           : wrStatus ? ((psWrData & `SSR_SW_MASK)
                             | (savedStatusReg & ~`SSR_SW_MASK))
                           : savedStatusReg;
  assign savedPcNext     = captureEn ? savedPcWord
                           : (wrDebug && accessId == REG_SAVED_PC) ? psWrData
                           : savedPcReg;
  assign savedSpNext     = captureEn ? savedSpWord
                           : (wrDebug && accessId == REG_SAVED_SP) ? psWrData
                           : savedSpReg;
  assign threadSelNext   = (wrDebug && accessId == REG_THREAD_SEL)
                           ? (psWrData & `THREAD_SEL_MASK) : threadSelReg;
  assign regSelNext      = (wrDebug && accessId == REG_REG_SEL)
                           ? (psWrData & `REG_SEL_MASK) : regSelReg;

  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      savedStatusReg <= 32'h0000_0000;
      savedPcReg     <= 32'h0000_0000;
      savedSpReg     <= 32'h0000_0000;
      threadSelReg   <= 32'h0000_0000;
      regSelReg      <= 32'h0000_0000;
    end
    else if (clockEnable)
    begin
      savedStatusReg <= savedStatusNext;
      savedPcReg     <= savedPcNext;
      savedSpReg     <= savedSpNext;
      threadSelReg   <= threadSelNext;
      regSelReg      <= regSelNext;
    end
  end

  assign targetThreadNumber  = threadSelReg[7:0];
  assign debugRegisterSelect = regSelReg[4:0];

  // ==========================================================
  // Read path
  word_t     rdMux;
  wire [1:0] countIdx;
  wire [1:0] countIdxNarrow;

  assign countIdxNarrow = 2'(psAddr - `OFS_OSC_COUNT0);
  assign countIdx       = countIdxNarrow;
  assign rdMux = (accessId == REG_SECURITY)     ? securityReg
               : (accessId == REG_OSC_CTRL)     ? oscCtrlReg
               : (accessId == REG_OSC_COUNT)    ? {16'h0000, oscCount[countIdx]}
               : (accessId == REG_MEM_SIZE)     ? (`MEM_SIZE_BYTES & `MEM_SIZE_MASK)
               : (accessId == REG_SAVED_STATUS) ? savedStatusReg
               : (accessId == REG_SAVED_PC)     ? savedPcReg
               : (accessId == REG_SAVED_SP)     ? savedSpReg
               : (accessId == REG_THREAD_SEL)   ? threadSelReg
               : (accessId == REG_REG_SEL)      ? regSelReg
               : 32'h0000_0000;

  always_ff @(posedge clock or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      psRdData    <= 32'h0000_0000;
      psRdValid   <= 1'b0;
      psWrRefused <= 1'b0;
    end
    else if (clockEnable)
    begin
      psRdValid   <= psRead;
      psWrRefused <= wrRefused;
      if (psRead)
        psRdData <= rdMux;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstSync_b);

  sequence sWriteLocked;
    clockEnable && writeLockSelf && !otpSecLoad;
  endsequence

  sequence sDebugEntry;
    clockEnable && dbgEntry && !globalDebugBlock;
  endsequence

  chk_lock_holds_word: assert property (
    sWriteLocked |=> $stable(securityReg))
    else $error("Security word changed while locked");

  chk_gdbg_no_capture: assert property (
    clockEnable && globalDebugBlock && dbgEntry && !psWrite |=> $stable(savedPcReg))
    else $error("Debug capture taken while global debug blocked");

  chk_otp_load_mirror: assert property (
    clockEnable && otpSecLoad |=> securityReg == ($past(otpSecWord) & `SEC_IMPL_MASK))
    else $error("Security word does not mirror OTP load");

  chk_osc_reset_off: assert property (
    $rose(rstSync_b) |-> !coreOscRun && !periphOscRun)
    else $error("Oscillator enables not cleared at reset");

  chk_count_upper_zero: assert property (
    psRdValid && $past(accessId) == REG_OSC_COUNT |-> psRdData[31:16] == 16'h0000)
    else $error("Count word upper bits not zero");

  chk_count_sync_step: assert property (
    clockEnable && tapSync[0] && !tapPrev[0] |=> oscCount[0] == $past(oscCount[0]) + 16'h0001)
    else $error("Counter missed a synchronised edge");

  chk_capture_status: assert property (
    sDebugEntry ##1 1'b1 |-> savedStatusReg == ($past(threadStatusWord) & `SSR_IMPL_MASK))
    else $error("Saved status not captured on debug entry");

  chk_capture_pc_sp: assert property (
    sDebugEntry |=> savedPcReg == $past(savedPcWord) && savedSpReg == $past(savedSpWord))
    else $error("Saved pc or sp not captured on debug entry");

  chk_issue_mode_ro: assert property (
    clockEnable && psWrite && !dbgEntry |=> savedStatusReg[`SSR_ISSUE_MODE]
      == $past(savedStatusReg[`SSR_ISSUE_MODE]))
    else $error("Issue mode bit changed by a write");

  chk_mem_size_low: assert property (
    psRdValid && $past(accessId) == REG_MEM_SIZE |-> psRdData[1:0] == 2'h0)
    else $error("Memory size low bits not zero");

  chk_sel_widths: assert property (
    threadSelReg[31:8] == 24'h000000 && regSelReg[31:5] == 27'h0000000)
    else $error("Reserved select bits set");

  chk_read_latency: assert property (
    clockEnable && psRead |=> psRdValid)
    else $error("Read answer not given next cycle");

  chk_refuse_locked: assert property (
    clockEnable && psWrite && accessId == REG_SECURITY && writeLockSelf |=> psWrRefused)
    else $error("Locked security write not refused");

  chk_gdbg_no_write: assert property (
    clockEnable && psWrite && globalDebugBlock && accessId == REG_SAVED_PC
      |=> $stable(savedPcReg))
    else $error("Debug write taken while global debug blocked");

  chk_osc_ctrl_write: assert property (
    clockEnable && wrOscCtrl |=> coreOscRun == $past(psWrData[`OSC_CORE_RUN])
      && periphOscRun == $past(psWrData[`OSC_PERIPH_RUN]))
    else $error("Oscillator enables not written");

  chk_count_keep_reset: assert property (
    disable iff (1'b0) !rstSync_b && !(tapSync[0] && !tapPrev[0]) |=> $stable(oscCount[0]))
    else $error("Counter changed by system reset");

  chk_thread_sel_write: assert property (
    clockEnable && wrDebug && accessId == REG_THREAD_SEL
      |=> targetThreadNumber == $past(psWrData[7:0]))
    else $error("Thread select not written");

  chk_status_sw_write: assert property (
    clockEnable && wrStatus && !captureEn |=> savedStatusReg[1:0] == $past(psWrData[1:0]))
    else $error("Status enable bits not written");

endmodule // proc_status_regs

`default_nettype wire

// ===== proc_status_regs_tb_top.sv
// Self-checking bench for the processor status register slice.
// Assumes the package and params header compile first.
`timescale 1ns/1ns
`default_nettype none

module proc_status_regs_tb_top;
  import proc_status_pkg::*;
  // ==========================================================
  // Signals
  logic       clock;
  logic       rst_b;
  logic       clockEnable;
  logic       psWrite;
  logic       psRead;
  ps_addr_t   psAddr;
  word_t      psWrData;
  word_t      psRdData;
  logic       psRdValid;
  logic       psWrRefused;
  logic       otpSecLoad;
  word_t      otpSecWord;
  logic       debugMode;
  logic       dbgEntry;
  word_t      threadStatusWord;
  word_t      savedPcWord;
  word_t      savedSpWord;
  logic [3:0] oscTap;
  logic       coreOscRun;
  logic       periphOscRun;
  logic       writeLockSelf;
  logic       globalDebugBlock;
  logic       otpLockAll;
  logic [3:0] otpLockPerSector;
  logic       otpRedundancyOn;
  logic       bootFromOtpOverride;
  logic       scanConfigBlock;
  logic       scanDebugPortBlock;
  logic [7:0] targetThreadNumber;
  logic [4:0] debugRegisterSelect;
  word_t      lastRd;
  osc_count_t base [4];
  int         nErrors;
  int         nChecks;
  int         cycles;

  proc_status_regs DUT (.clock(clock), .rst_b(rst_b), .clockEnable(clockEnable),
    .psWrite(psWrite), .psRead(psRead), .psAddr(psAddr), .psWrData(psWrData),
    .psRdData(psRdData), .psRdValid(psRdValid), .psWrRefused(psWrRefused),
    .otpSecLoad(otpSecLoad), .otpSecWord(otpSecWord), .debugMode(debugMode),
    .dbgEntry(dbgEntry), .threadStatusWord(threadStatusWord),
    .savedPcWord(savedPcWord), .savedSpWord(savedSpWord), .oscTap(oscTap),
    .coreOscRun(coreOscRun), .periphOscRun(periphOscRun),
    .writeLockSelf(writeLockSelf), .globalDebugBlock(globalDebugBlock),
    .otpLockAll(otpLockAll), .otpLockPerSector(otpLockPerSector),
    .otpRedundancyOn(otpRedundancyOn), .bootFromOtpOverride(bootFromOtpOverride),
    .scanConfigBlock(scanConfigBlock), .scanDebugPortBlock(scanDebugPortBlock),
    .targetThreadNumber(targetThreadNumber), .debugRegisterSelect(debugRegisterSelect));

  // ==========================================================
  // Clock and timeout
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      nErrors = nErrors + 1;
      endSim();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string name, input word_t seen, input word_t exp);
    nChecks = nChecks + 1;
    if (seen !== exp)
    begin
      nErrors = nErrors + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic endSim();
    $display("checks %0d errors %0d", nChecks, nErrors);
    if (nErrors == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic doReset();
    rst_b = 1'b0;
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    repeat (3) @(negedge clock);
  endtask

  task automatic wr(input ps_addr_t a, input word_t d, input logic refExp);
    psWrite = 1'b1;
    psAddr = a;
    psWrData = d;
    @(negedge clock);
    psWrite = 1'b0;
    chk("psWrRefused", {31'h0, psWrRefused}, {31'h0, refExp});
    @(negedge clock);
  endtask

  task automatic rd(input ps_addr_t a, input word_t e);
    psRead = 1'b1;
    psAddr = a;
    @(negedge clock);
    psRead = 1'b0;
    lastRd = psRdData;
    chk("psRdValid", {31'h0, psRdValid}, 32'h1);
    chk("psRdData", psRdData, e);
    @(negedge clock);
  endtask

  task automatic otpLoad(input word_t w);
    otpSecLoad = 1'b1;
    otpSecWord = w;
    @(negedge clock);
    otpSecLoad = 1'b0;
  endtask

  task automatic dbgEnter(input word_t s, input word_t p, input word_t q);
    dbgEntry = 1'b1;
    threadStatusWord = s;
    savedPcWord = p;
    savedSpWord = q;
    @(negedge clock);
    dbgEntry = 1'b0;
  endtask

  function automatic word_t secFlags(input word_t w);
    return {21'h0, w[31], w[14], w[12], w[11:8], w[7], w[5], w[4], w[0]};
  endfunction

  function automatic word_t secOut();
    return {21'h0, writeLockSelf, globalDebugBlock, otpLockAll, otpLockPerSector,
      otpRedundancyOn, bootFromOtpOverride, scanConfigBlock, scanDebugPortBlock};
  endfunction

  // ==========================================================
  // Main sequence
  initial
  begin
    {rst_b, psWrite, psRead, otpSecLoad, debugMode, dbgEntry} = '0;
    {psAddr, psWrData, otpSecWord, oscTap} = '0;
    {threadStatusWord, savedPcWord, savedSpWord} = '0;
    clockEnable = 1'b1;
    nErrors = 0;
    nChecks = 0;
    cycles = 0;
    doReset();
    // Oscillator control and frozen clock enable
    rd(`OFS_OSC_CTRL, 32'h0);
    clockEnable = 1'b0;
    wr(`OFS_OSC_CTRL, 32'hFFFF_FFFF, 1'b0);
    clockEnable = 1'b1;
    rd(`OFS_OSC_CTRL, 32'h0);
    wr(`OFS_OSC_CTRL, 32'hFFFF_FFFF, 1'b0);
    rd(`OFS_OSC_CTRL, 32'h3);
    chk("oscRun", {30'h0, coreOscRun, periphOscRun}, 32'h3);
    // Read-only and unmapped places
    wr(`OFS_MEM_SIZE, 32'h0, 1'b0);
    rd(`OFS_MEM_SIZE, `MEM_SIZE_BYTES & `MEM_SIZE_MASK);
    rd(8'h0B, 32'h0);
    // Oscillator counters, distinct pulse counts per tap
    for (int i = 0; i < 4; i++)
    begin
      rd(`OFS_OSC_COUNT0 + 8'(i), 32'h0);
      base[i] = lastRd[15:0];
    end
    for (int p = 0; p < 12; p++)
    begin
      for (int i = 0; i < 4; i++)
        oscTap[i] = (p < 3 * (i + 1));
      repeat (3) @(negedge clock);
      oscTap = 4'h0;
      repeat (3) @(negedge clock);
    end
    wr(`OFS_OSC_CTRL, 32'h0, 1'b0);
    chk("oscRun", {30'h0, coreOscRun, periphOscRun}, 32'h0);
    repeat (10) @(negedge clock);
    for (int i = 0; i < 4; i++)
    begin
      rd(`OFS_OSC_COUNT0 + 8'(i), {16'h0, base[i] + 16'(3 * (i + 1))});
      base[i] = lastRd[15:0];
    end
    // Debug capture and software access
    wr(`OFS_SAVED_PC, 32'h1234_5678, 1'b1);
    dbgEnter(32'hFFFF_FFFF, 32'hA5A5_0F0F, 32'h5A5A_F0F0);
    rd(`OFS_SAVED_STATUS, `SSR_IMPL_MASK);
    rd(`OFS_SAVED_PC, 32'hA5A5_0F0F);
    rd(`OFS_SAVED_SP, 32'h5A5A_F0F0);
    debugMode = 1'b1;
    wr(`OFS_SAVED_STATUS, 32'h0, 1'b0);
    rd(`OFS_SAVED_STATUS, 32'h0000_0100);
    wr(`OFS_SAVED_STATUS, 32'hFFFF_FEFF, 1'b0);
    rd(`OFS_SAVED_STATUS, `SSR_IMPL_MASK);
    wr(`OFS_SAVED_SP, 32'h0BAD_CAFE, 1'b0);
    rd(`OFS_SAVED_SP, 32'h0BAD_CAFE);
    wr(`OFS_THREAD_SEL, 32'hFFFF_FFFF, 1'b0);
    rd(`OFS_THREAD_SEL, `THREAD_SEL_MASK);
    chk("targetThreadNumber", {24'h0, targetThreadNumber}, 32'hFF);
    wr(`OFS_REG_SEL, 32'hFFFF_FFE5, 1'b0);
    rd(`OFS_REG_SEL, 32'h0000_0005);
    chk("debugRegisterSelect", {27'h0, debugRegisterSelect}, 32'h5);
    // Security word fields, lock and OTP load
    wr(`OFS_SECURITY, 32'h7FFF_FFFF, 1'b0);
    rd(`OFS_SECURITY, 32'h0000_5FB1);
    chk("securityFlags", secOut(), secFlags(32'h0000_5FB1));
    wr(`OFS_SAVED_PC, 32'h1111_2222, 1'b1);
    dbgEnter(32'h0, 32'h3333_4444, 32'h0);
    rd(`OFS_SAVED_PC, 32'hA5A5_0F0F);
    wr(`OFS_SECURITY, 32'h8000_0000, 1'b0);
    chk("securityFlags", secOut(), secFlags(32'h8000_0000));
    wr(`OFS_SECURITY, 32'h0000_0001, 1'b1);
    rd(`OFS_SECURITY, 32'h8000_0000);
    otpLoad(32'hFFFF_AF21);
    rd(`OFS_SECURITY, 32'h8000_0F21);
    chk("securityFlags", secOut(), secFlags(32'h8000_0F21));
    otpLoad(32'h0000_0010);
    wr(`OFS_SECURITY, 32'h0000_0090, 1'b0);
    rd(`OFS_SECURITY, 32'h0000_0090);
    // Second reset keeps counters
    wr(`OFS_OSC_CTRL, 32'h3, 1'b0);
    doReset();
    rd(`OFS_OSC_CTRL, 32'h0);
    rd(`OFS_SECURITY, 32'h0);
    for (int i = 0; i < 4; i++)
      rd(`OFS_OSC_COUNT0 + 8'(i), {16'h0, base[i]});
    endSim();
  end
endmodule // proc_status_regs_tb_top

`default_nettype wire
